// ==== logic/cic_pkg.sv ====
// cic_pkg: shared constants, register map and carriers of the core interrupt controller
// assumes an APB slave with 32-bit data, one register per aligned word
package cic_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] PEN1_OFS = 12'h004;
  localparam logic [11:0] PEN2_OFS = 12'h008;
  localparam logic [11:0] PFLG1_OFS = 12'h00C;
  localparam logic [11:0] PFLG2_OFS = 12'h010;
  localparam logic [11:0] PCHG_OFS = 12'h014;
  localparam logic [11:0] OPT_OFS = 12'h018;
  localparam logic [11:0] STAT_OFS = 12'h01C;
  // shadow copies live in bank 31 of data memory
  localparam logic [11:0] SHD_BASE = 12'hF80;
  localparam int SHD_WORDS = 8;
  localparam logic [7:0] BANK_SHADOW = 8'h1F;
  // control and option register fields
  localparam int GIE_POS = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_POS = 6;
  localparam int TMR0E_POS = 5;
  localparam int EXT_IRQ_PIN_ENABLE_POS = 4;
  localparam int IOCE_POS = 3;
  localparam int TMR0F_POS = 2;
  localparam int EXT_IRQ_FLAG_POS = 1;
  localparam int IOCF_POS = 0;
  localparam int EDGE_POS = 6;
  // status bits saved in the shadow but kept live on restore
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'hFF;
  // vector and cycle figures
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int QUARTERS = 4;
  localparam int SYNC_LATENCY_CYC = 3;
  typedef struct packed {
    logic [7:0] wreg;
    logic [7:0] status;
    logic [7:0] bank_select_reg;
    logic [7:0] fsr0l;
    logic [7:0] fsr0h;
    logic [7:0] fsr1l;
    logic [7:0] fsr1h;
    logic [7:0] pc_high_latch;
  } cic_ctx_s;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FLUSH = 2'b01,
    ST_ENTER = 2'b10,
    ST_SLEEP = 2'b11
  } cic_state_e;
endpackage : cic_pkg

// ==== logic/cic_edge.sv ====
// cic_edge: external pin edge detector with first-quarter sampling
// assumes pin already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module cic_edge (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pin and config
  input wire logic pin_i,
  input wire logic edge_rise_i,
  input wire logic q1_i,
  // result
  output logic hit_o
);
  logic prev_ff;
  logic seen_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pin_i;
    end
  end
  wire logic edge_now = edge_rise_i ? (pin_i & ~prev_ff) : (~pin_i & prev_ff);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_ff <= 1'b0;
    end else if (q1_i) begin
      seen_ff <= 1'b0;
    end else if (edge_now) begin
      seen_ff <= 1'b1;
    end
  end
  assign hit_o = q1_i & (seen_ff | edge_now);
endmodule // cic_edge
`default_nettype wire

// ==== logic/cic_ctrl.sv ====
// cic_ctrl: flags, enables, vectoring, context shadowing and sleep wake
// Operation
// - reset disables every interrupt source
// - take needs global and own enable, plus peripheral-group enable for peripheral flags
// - flags set regardless of enables
// - entry flushes, clears global, pushes, saves, vectors
// - in service, flags set, no redirection
// - return pops, restores, sets global enable
// - pending event served when global returns
// - synchronous latency three or four cycles
// - asynchronous latency three to five cycles
// - latency independent of instruction length
// - pin flag sampled each first quarter
// - wake vectors only with global enable
// - instruction after sleep always executes
// - pin edge chosen by select bit
// - valid pin edge sets flag, may vector
// - entry copies context into shadow copies
// - return reloads shadows, writes alter restore
// - shadows in bank 31, read/write
// - pin-change summary read-only, clears when all clear
// assumes core gives instruction-cycle phase, accepts flush/push/vector pulses
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl #(
  parameter int NUM_IOC = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources
  input wire logic tmr0_evt_i,
  input wire logic [7:0] per1_evt_i,
  input wire logic [7:0] per2_evt_i,
  input wire logic [NUM_IOC-1:0] ioc_evt_i,
  input wire logic ext_pin_i,
  // core side
  input wire logic [1:0] quarter_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic return_from_service_i,
  input wire cic_pkg::cic_ctx_s ctx_i,
  output logic flush_o,
  output logic push_pc_o,
  output logic vector_o,
  output logic [14:0] vector_addr_o,
  output logic restore_o,
  output cic_pkg::cic_ctx_s ctx_o,
  output logic in_service_o,
  output logic sleeping_o
);
  // elaboration check: the pin-change field is one byte at most
  if (NUM_IOC < 1 || NUM_IOC > 8) begin : g_bad_ioc
    $error("NUM_IOC must be 1..8");
  end
  logic [7:0] ctrl_ff;
  logic [7:0] pen1_ff;
  logic [7:0] pen2_ff;
  logic [7:0] pflg1_ff;
  logic [7:0] pflg2_ff;
  logic [NUM_IOC-1:0] pchg_ff;
  logic [7:0] opt_ff;
  cic_pkg::cic_state_e state_ff;
  logic [7:0] shd_ff [cic_pkg::SHD_WORDS];
  logic [31:0] nxt_prdata;
  logic ext_hit;
  logic pend_any;
  logic q1;
  logic wr;
  logic rd;
  logic hit_map;
  logic [7:0] ctrl_wr;
  assign q1 = (quarter_i == 2'd0);
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_map;
  function automatic logic [7:0] wbyte(input logic [11:0] a, input logic [11:0] o,
                                       input logic [7:0] cur, input logic [31:0] d);
    wbyte = (a == o) ? d[7:0] : cur;
  endfunction
  cic_edge u_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_pin_i),
    .edge_rise_i(opt_ff[cic_pkg::EDGE_POS]),
    .q1_i(q1),
    .hit_o(ext_hit)
  );
  assign pend_any =
    (ctrl_ff[cic_pkg::TMR0E_POS] & ctrl_ff[cic_pkg::TMR0F_POS]) |
    (ctrl_ff[cic_pkg::EXT_IRQ_PIN_ENABLE_POS] & ctrl_ff[cic_pkg::EXT_IRQ_FLAG_POS]) |
    (ctrl_ff[cic_pkg::IOCE_POS] & ctrl_ff[cic_pkg::IOCF_POS]) |
    (ctrl_ff[cic_pkg::PERIPHERAL_IRQ_ENABLE_POS] & (|(pen1_ff & pflg1_ff) | |(pen2_ff & pflg2_ff)));
  wire logic global_irq_enable = ctrl_ff[cic_pkg::GIE_POS];
  assign ctrl_wr = wbyte(paddr, cic_pkg::CTRL_OFS, ctrl_ff, pwdata);
  wire logic enter = (state_ff == cic_pkg::ST_ENTER);
  // reset clears enables; flags set regardless of enables
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= cic_pkg::CTRL_RST;
    end else begin
      logic [7:0] c;
      c = ctrl_ff;
      if (wr) begin
        c[7:1] = ctrl_wr[7:1];
      end
      if (enter) begin
        c[cic_pkg::GIE_POS] = 1'b0;
      end
      if (return_from_service_i) begin
        c[cic_pkg::GIE_POS] = 1'b1;
      end
      if (tmr0_evt_i) begin
        c[cic_pkg::TMR0F_POS] = 1'b1;
      end
      if (ext_hit) begin
        c[cic_pkg::EXT_IRQ_FLAG_POS] = 1'b1;
      end
      c[cic_pkg::IOCF_POS] = |pchg_ff | |ioc_evt_i;
      ctrl_ff <= c;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pen1_ff <= 8'h00;
      pen2_ff <= 8'h00;
      opt_ff <= cic_pkg::OPT_RST;
    end else if (wr) begin
      pen1_ff <= wbyte(paddr, cic_pkg::PEN1_OFS, pen1_ff, pwdata);
      pen2_ff <= wbyte(paddr, cic_pkg::PEN2_OFS, pen2_ff, pwdata);
      opt_ff <= wbyte(paddr, cic_pkg::OPT_OFS, opt_ff, pwdata);
    end
  end
  // peripheral flags, set wins over clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pflg1_ff <= 8'h00;
      pflg2_ff <= 8'h00;
      pchg_ff <= '0;
    end else begin
      pflg1_ff <= (wr ? wbyte(paddr, cic_pkg::PFLG1_OFS, pflg1_ff, pwdata) : pflg1_ff)
                  | per1_evt_i;
      pflg2_ff <= (wr ? wbyte(paddr, cic_pkg::PFLG2_OFS, pflg2_ff, pwdata) : pflg2_ff)
                  | per2_evt_i;
      pchg_ff <= ((wr && paddr == cic_pkg::PCHG_OFS) ? pwdata[NUM_IOC-1:0] : pchg_ff)
                 | ioc_evt_i;
    end
  end
  // take only at first quarter, fixed entry sequence
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= cic_pkg::ST_RUN;
    end else begin
      case (state_ff)
        cic_pkg::ST_RUN: begin
          if (sleep_i) begin
            state_ff <= cic_pkg::ST_SLEEP;
          end else if (q1 && global_irq_enable && pend_any) begin
            state_ff <= cic_pkg::ST_FLUSH;
          end
        end
        cic_pkg::ST_FLUSH: begin
          if (q1) begin
            state_ff <= cic_pkg::ST_ENTER;
          end
        end
        cic_pkg::ST_ENTER: begin
          state_ff <= cic_pkg::ST_RUN;
        end
        cic_pkg::ST_SLEEP: begin
          // back to run; next instruction runs before any take
          if (wake_i || pend_any) begin
            state_ff <= cic_pkg::ST_RUN;
          end
        end
        default: begin
          state_ff <= cic_pkg::ST_RUN;
        end
      endcase
    end
  end
  assign flush_o = (state_ff == cic_pkg::ST_FLUSH) & q1;
  assign push_pc_o = enter;
  assign vector_o = enter;
  assign vector_addr_o = cic_pkg::IRQ_VECTOR;
  assign restore_o = return_from_service_i;
  assign sleeping_o = (state_ff == cic_pkg::ST_SLEEP);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_service_o <= 1'b0;
    end else if (enter) begin
      in_service_o <= 1'b1;
    end else if (return_from_service_i) begin
      in_service_o <= 1'b0;
    end
  end
  // save on entry; shadows writable by software
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < cic_pkg::SHD_WORDS; i++) begin
        shd_ff[i] <= 8'h00;
      end
    end else if (enter) begin
      for (int i = 0; i < cic_pkg::SHD_WORDS; i++) begin
        shd_ff[i] <= ctx_i[8*(cic_pkg::SHD_WORDS-1-i) +: 8];
      end
    end else if (wr && paddr[11:5] == cic_pkg::SHD_BASE[11:5]) begin
      shd_ff[paddr[4:2]] <= pwdata[7:0];
    end
  end
  // restore from shadows; status keeps its timeout and powerdown bits
  always_comb begin
    for (int i = 0; i < cic_pkg::SHD_WORDS; i++) begin
      ctx_o[8*(cic_pkg::SHD_WORDS-1-i) +: 8] = shd_ff[i];
    end
    ctx_o.status = (shd_ff[1] & ~cic_pkg::STATUS_KEEP_MASK)
                 | (ctx_i.status & cic_pkg::STATUS_KEEP_MASK);
  end
  always_comb begin
    hit_map = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      cic_pkg::CTRL_OFS: nxt_prdata[7:0] = ctrl_ff;
      cic_pkg::PEN1_OFS: nxt_prdata[7:0] = pen1_ff;
      cic_pkg::PEN2_OFS: nxt_prdata[7:0] = pen2_ff;
      cic_pkg::PFLG1_OFS: nxt_prdata[7:0] = pflg1_ff;
      cic_pkg::PFLG2_OFS: nxt_prdata[7:0] = pflg2_ff;
      cic_pkg::PCHG_OFS: nxt_prdata[NUM_IOC-1:0] = pchg_ff;
      cic_pkg::OPT_OFS: nxt_prdata[7:0] = opt_ff;
      cic_pkg::STAT_OFS: nxt_prdata[2:0] = {in_service_o, sleeping_o, pend_any};
      default: begin
        if (paddr[11:5] == cic_pkg::SHD_BASE[11:5] && paddr[1:0] == 2'b00) begin
          nxt_prdata[7:0] = shd_ff[paddr[4:2]];
        end else begin
          hit_map = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= nxt_prdata;
    end
  end
  a_entry_clears_gie: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    enter |=> !global_irq_enable || $past(return_from_service_i)) else $error("gie not cleared");
  a_take_needs_gie: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_ff == cic_pkg::ST_FLUSH) |-> $past(global_irq_enable && pend_any && q1))
    else $error("take without enable");
  a_no_take_sleep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_ff == cic_pkg::ST_SLEEP) |=> state_ff != cic_pkg::ST_FLUSH)
    else $error("take straight from sleep");
  a_flag_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tmr0_evt_i |=> ctrl_ff[cic_pkg::TMR0F_POS]) else $error("flag not set");
  a_ret_sets_gie: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    return_from_service_i |=> global_irq_enable) else $error("return missed gie");
  a_ext_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ext_hit |=> ctrl_ff[cic_pkg::EXT_IRQ_FLAG_POS]) else $error("pin flag missed");
  a_ext_at_q1: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ext_hit |-> q1) else $error("pin flag off q1");
  a_summary_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 ctrl_ff[cic_pkg::IOCF_POS] == ($past(|pchg_ff) || $past(|ioc_evt_i)))
    else $error("summary wrong");
  a_entry_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_ff == cic_pkg::ST_FLUSH) |-> ##[1:5] enter)
    else $error("entry too slow");
  c_take: cover property (@(posedge clk_i) disable iff (!rst_b_i) enter);
  c_return: cover property (@(posedge clk_i) disable iff (!rst_b_i) return_from_service_i);
  c_wake: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(sleeping_o));
endmodule // cic_ctrl
`default_nettype wire

// ==== verification/cic_core_model.sv ====
// cic_core_model: processor core stand-in beside the interrupt controller
// assumes the controller's clock and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cic_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // controller requests
  input wire logic vector_i,
  input wire logic push_pc_i,
  // core state
  output logic [1:0] quarter_o,
  output cic_pkg::cic_ctx_s ctx_o,
  output logic [7:0] vec_cnt_o
);
  logic [1:0] quarter_ff;
  logic [7:0] vec_cnt_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) quarter_ff <= 2'h0;
    else quarter_ff <= quarter_ff + 2'h1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) vec_cnt_ff <= 8'h00;
    else if (vector_i && push_pc_i) vec_cnt_ff <= vec_cnt_ff + 8'h01;
  end
  // live working value moves on after each entry, so a restore cannot echo it
  assign ctx_o = {8'h3C + vec_cnt_ff, 8'h1F, 48'h0};
  assign quarter_o = quarter_ff;
  assign vec_cnt_o = vec_cnt_ff;
endmodule // cic_core_model
`default_nettype wire

// ==== verification/cic_ctrl_tb.sv ====
// cic_ctrl_tb: register-level tests of the interrupt controller
// assumes the core model beside it supplies phase and live context
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, tmr0_evt = 1'b0, ext_pin = 1'b0;
  logic sleep = 1'b0, wake = 1'b0, ret = 1'b0;
  logic [7:0] per1_evt = 8'h00, ioc_evt = 8'h00, vec_cnt;
  logic [1:0] quarter;
  logic flush, push_pc, vector, restore, in_service, sleeping;
  logic [14:0] vec_addr;
  cic_pkg::cic_ctx_s ctx_live, ctx_back;
  int failures = 0, tests_run = 0, cyc = 0, n;
  always #25 clk_i = ~clk_i;
  cic_ctrl i_cic_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr0_evt_i(tmr0_evt), .per1_evt_i(per1_evt), .per2_evt_i(8'h00),
    .ioc_evt_i(ioc_evt), .ext_pin_i(ext_pin), .quarter_i(quarter), .sleep_i(sleep),
    .wake_i(wake), .return_from_service_i(ret), .ctx_i(ctx_live), .flush_o(flush),
    .push_pc_o(push_pc), .vector_o(vector), .vector_addr_o(vec_addr), .restore_o(restore),
    .ctx_o(ctx_back), .in_service_o(in_service), .sleeping_o(sleeping));
  cic_core_model i_cic_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .vector_i(vector),
    .push_pc_i(push_pc), .quarter_o(quarter), .ctx_o(ctx_live), .vec_cnt_o(vec_cnt));
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q, exp);
  endtask
  task automatic wait_vec();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (vector !== 1'b1 && n < 40);
    @(posedge clk_i);
  endtask
  task automatic pin_to(input logic v);
    ext_pin <= v;
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(cic_pkg::CTRL_OFS, 32'h0);
    rd(cic_pkg::OPT_OFS, 32'hFF);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    per1_evt <= 8'h01;
    @(posedge clk_i);
    per1_evt <= 8'h00;
    rd(cic_pkg::PFLG1_OFS, 32'h1);
    wr(cic_pkg::PEN1_OFS, 32'h1);
    wr(cic_pkg::CTRL_OFS, 32'h80);
    repeat (16) @(posedge clk_i);
    chk("vec_cnt", 32'(vec_cnt), 32'h0);
    wr(cic_pkg::CTRL_OFS, 32'hC0);
    wait_vec();
    chk("latency", 32'(n <= 16), 32'h1);
    chk("vec_addr", 32'(vec_addr), 32'h4);
    rd(cic_pkg::CTRL_OFS, 32'h40);
    chk("vec_cnt", 32'(vec_cnt), 32'h1);
    tmr0_evt <= 1'b1;
    @(posedge clk_i);
    tmr0_evt <= 1'b0;
    rd(cic_pkg::CTRL_OFS, 32'h44);
    chk("vec_cnt", 32'(vec_cnt), 32'h1);
    rd(cic_pkg::SHD_BASE, 32'h3C);
    wr(cic_pkg::SHD_BASE, 32'h5A);
    rd(cic_pkg::SHD_BASE, 32'h5A);
    wr(cic_pkg::PFLG1_OFS, 32'h0);
    wr(cic_pkg::CTRL_OFS, 32'h40);
    ret <= 1'b1;
    @(negedge clk_i);
    chk("restore", 32'(restore), 32'h1);
    chk("ctx_w", 32'(ctx_back.wreg), 32'h5A);
    @(posedge clk_i);
    ret <= 1'b0;
    rd(cic_pkg::CTRL_OFS, 32'hC0);
    chk("in_service", 32'(in_service), 32'h0);
    ioc_evt <= 8'h01;
    @(posedge clk_i);
    ioc_evt <= 8'h00;
    rd(cic_pkg::CTRL_OFS, 32'hC1);
    wr(cic_pkg::CTRL_OFS, 32'hC0);
    rd(cic_pkg::CTRL_OFS, 32'hC1);
    wr(cic_pkg::PCHG_OFS, 32'h0);
    rd(cic_pkg::CTRL_OFS, 32'hC0);
    pin_to(1'b1);
    rd(cic_pkg::CTRL_OFS, 32'hC2);
    wr(cic_pkg::CTRL_OFS, 32'hC0);
    wr(cic_pkg::OPT_OFS, 32'hBF);
    pin_to(1'b0);
    rd(cic_pkg::CTRL_OFS, 32'hC2);
    wr(cic_pkg::CTRL_OFS, 32'hC0);
    pin_to(1'b1);
    rd(cic_pkg::CTRL_OFS, 32'hC0);
    wr(cic_pkg::CTRL_OFS, 32'hD0);
    ext_pin <= 1'b0;
    wait_vec();
    chk("latency", 32'(n <= 20), 32'h1);
    rd(cic_pkg::CTRL_OFS, 32'h52);
    wr(cic_pkg::CTRL_OFS, 32'h50);
    sleep <= 1'b1;
    @(posedge clk_i);
    sleep <= 1'b0;
    @(negedge clk_i);
    chk("sleeping", 32'(sleeping), 32'h1);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("sleeping", 32'(sleeping), 32'h1);
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    @(negedge clk_i);
    chk("sleeping", 32'(sleeping), 32'h0);
    final_report();
  end
endmodule // cic_ctrl_tb
`default_nettype wire
